// file: core/spfe_defs.vh
// spfe_defs.vh: constants of the serial command front end.
// assumes it is included by bare name from the front end source only.
`ifndef SPFE_DEFS_VH
`define SPFE_DEFS_VH

// frame geometry, counted in falling serial clock edges
`define SPFE_CNT_W          5
`define SPFE_CNT_ZERO       5'h00
`define SPFE_CNT_ONE        5'h01
`define SPFE_ADDR_DONE      5'h02
`define SPFE_INSTRUCTION_CODE_DONE     5'h07
`define SPFE_PARITY_DONE    5'h08
`define SPFE_FRAME_BITS     5'h10
`define SPFE_CNT_SAT        5'h11

// first byte layout
`define SPFE_CODE_W         5
`define SPFE_CODE_MSB       4
`define SPFE_ADDR_HI        6
`define SPFE_ADDR_LO        5
`define SPFE_CHIP_ADDR      2'h0
`define SPFE_RX_W           7

// verification byte: two undriven bits, fixed pattern, error flag
`define SPFE_VERIFY_HIGH    2'h0
`define SPFE_VERIFY_PATTERN 5'h15
`define SPFE_FLAG_RESET     1'h0

// data byte answers
`define SPFE_BYTE_W         8
`define SPFE_DATA_INVALID   8'hFF
`define SPFE_DATA_WRITE     8'h00
`define SPFE_BYTE_ZERO      8'h00

// input synchroniser
`define SPFE_SYNC_DEPTH     3
`define SPFE_PIN_COUNT      3
`define SPFE_PIN_SCLK       0
`define SPFE_PIN_SS         1
`define SPFE_PIN_SDI        2
`define SPFE_PINS_IDLE      3'h2

// access kinds
`define SPFE_KIND_W         2
`define SPFE_KIND_NONE      2'h0
`define SPFE_KIND_READ      2'h1
`define SPFE_KIND_WRITE     2'h2
`define SPFE_KIND_CLEAR     2'h3

`endif

// file: core/spfe_frontend.v
// spfe_frontend.v: serial slave front end taking 16-bit command frames.
// assumes a system clock far faster than the serial clock (4 ns vs >= 48 ns),
// a decode table outside that classifies instruction codes and returns read data,
// and an outside tristate buffer that turns sdo/sdo_oe_n into the pin.
//
// pin latency is four to five clk from a pin change to the frame logic;
// all three pins share it, so data and clock keep their relative order.
// a serial half period shorter than about two clk breaks edge detection,
// which is why the link rate limit matters to this block as well.
// no supply monitor input exists: shutoff must not disturb the link.
//
// Summary of operation
// - first byte: address, code, parity bits
// - select high: serial output undriven
// - read: register contents shifted out MSB first
// - select high returns logic to idle
// - reset undrives output; supply shutoff ignored
// - verification byte: Z Z 10101 error flag
// - read access ignores incoming data bits
// - write or clear: output low afterwards
// - bits past sixteen are discarded
// - undefined code makes instruction invalid
// - unfinished previous processing makes it invalid
// - write/clear suppressed unless sixteen falling edges
// - write suppressed if clock high at end
// - invalid: no register change, answer FFh
// - valid read answers register despite bad parity
// - valid write answers 00h; update needs parity
// - error flag set, held until sent
// - respond only to own chip address
// - output undriven during address bits
`include "spfe_defs.vh"
`default_nettype none

module spfe_frontend (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      sclk,
  input  wire                      ss_n,
  input  wire                      sdi,
  output wire                      sdo,
  output reg                       sdo_oe_n,
  input  wire                      proc_busy,
  output wire [`SPFE_CODE_W-1:0]   instruction_code,
  input  wire                      code_is_read,
  input  wire                      code_is_write,
  input  wire                      code_is_clear,
  input  wire [`SPFE_BYTE_W-1:0]   read_data,
  output reg                       write_strobe,
  output reg  [`SPFE_CODE_W-1:0]   write_code,
  output reg  [`SPFE_BYTE_W-1:0]   write_data,
  output reg                       clear_diagnostics_cmd,
  output reg                       transfer_error_flag,
  output reg                       frame_active
);

  // frame states:
  //   idle  - deselected, waiting for select to fall
  //   addr  - first two bits in, output still undriven
  //   instruction_code - code and parity bits in, verification byte out
  //   data  - answer byte out, write data in
  //   skip  - foreign frame or bits past the frame: nothing taken
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_INSTRUCTION_CODE = 3'h2;
  localparam [2:0] ST_DATA  = 3'h3;
  localparam [2:0] ST_SKIP  = 3'h4;

  // even parity over the code and its parity bit
  function parity_ok;
    input [`SPFE_CODE_W-1:0] code;
    input                    par;
    begin
      parity_ok = ~(^{code, par});
    end
  endfunction

  // exactly one frame's worth of falling edges
  function full_frame;
    input [`SPFE_CNT_W-1:0] cnt;
    begin
      full_frame = (cnt == `SPFE_FRAME_BITS);
    end
  endfunction

  // pin synchronisers: three stages, a level is accepted once stages two and three agree
  // each stage resets to the idle level of its pin, so no false edge follows reset
  localparam [`SPFE_PIN_COUNT-1:0] PINS_IDLE = `SPFE_PINS_IDLE;
  wire [`SPFE_PIN_COUNT-1:0] pin_raw;
  wire [`SPFE_PIN_COUNT-1:0] pin_lvl;
  assign pin_raw = {sdi, ss_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < `SPFE_PIN_COUNT; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg lvl;
      assign pin_lvl[gi] = lvl;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1  <= PINS_IDLE[gi];
          s2  <= PINS_IDLE[gi];
          s3  <= PINS_IDLE[gi];
          lvl <= PINS_IDLE[gi];
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
    end
  endgenerate

  reg [`SPFE_PIN_COUNT-1:0] pin_prev;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev <= `SPFE_PINS_IDLE;
    end else begin
      pin_prev <= pin_lvl;
    end
  end

  wire sclk_lvl = pin_lvl[`SPFE_PIN_SCLK];
  wire sdi_lvl  = pin_lvl[`SPFE_PIN_SDI];
  wire ss_lvl   = pin_lvl[`SPFE_PIN_SS];
  wire sclk_fall = pin_prev[`SPFE_PIN_SCLK] & ~sclk_lvl;
  wire ss_fall   = pin_prev[`SPFE_PIN_SS] & ~ss_lvl;
  wire ss_rise   = ~pin_prev[`SPFE_PIN_SS] & ss_lvl;

  reg [2:0]               state;
  reg [`SPFE_CNT_W-1:0]   bit_cnt;
  reg [`SPFE_RX_W-1:0]    rx_shift;
  reg [`SPFE_BYTE_W-1:0]  tx_shift;
  reg [`SPFE_BYTE_W-1:0]  tx_data;
  reg [`SPFE_BYTE_W-1:0]  data_shift;
  reg [`SPFE_KIND_W-1:0]  kind;
  reg                     addressed;
  reg                     decide_pend;
  reg                     invalid;
  reg                     par_good;

  wire [`SPFE_CNT_W-1:0] cnt_inc = bit_cnt + `SPFE_CNT_ONE;
  wire                   in_frame = (bit_cnt < `SPFE_FRAME_BITS);

  // the code stays on the table port from the seventh bit to the next frame start
  assign instruction_code = rx_shift[`SPFE_CODE_MSB:0];
  assign sdo = tx_shift[`SPFE_BYTE_W-1];

  // frame sequencing on sampled serial clock edges
  // walk of one frame, counted in falling edges:
  //   1     first address bit in, output undriven
  //   2     address checked; own chip drives the pattern from here
  //   3..6  pattern bits, code bits shift in
  //   7     error flag on the pin, code complete, decision next clk
  //   8     parity bit in, answer byte loaded
  //   9..16 answer shifts out, write data shifts in
  //   17+   discarded, output low
  // select high overrides everything, so a cut frame always ends here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      bit_cnt     <= `SPFE_CNT_ZERO;
      rx_shift    <= {`SPFE_RX_W{1'b0}};
      tx_shift    <= `SPFE_BYTE_ZERO;
      data_shift  <= `SPFE_BYTE_ZERO;
      sdo_oe_n    <= 1'b1;
      addressed   <= 1'b0;
      decide_pend <= 1'b0;
      par_good    <= 1'b0;
      frame_active <= 1'b0;
    end else if (ss_lvl) begin
      // deselected: undrive the output and wait for a new instruction
      state        <= ST_IDLE;
      bit_cnt      <= `SPFE_CNT_ZERO;
      sdo_oe_n     <= 1'b1;
      decide_pend  <= 1'b0;
      frame_active <= 1'b0;
    end else if (ss_fall) begin
      // frame always opens with the instruction byte
      state        <= ST_ADDR;
      bit_cnt      <= `SPFE_CNT_ZERO;
      addressed    <= 1'b0;
      par_good     <= 1'b0;
      frame_active <= 1'b1;
      tx_shift     <= {`SPFE_VERIFY_HIGH, `SPFE_VERIFY_PATTERN, transfer_error_flag};
      sdo_oe_n     <= 1'b1;
    end else begin
      decide_pend <= 1'b0;
      if (sclk_fall) begin
        if (bit_cnt != `SPFE_CNT_SAT) begin
          bit_cnt <= cnt_inc;
        end
        case (state)
          ST_ADDR: begin
            rx_shift <= {rx_shift[`SPFE_RX_W-2:0], sdi_lvl};
            tx_shift <= {tx_shift[`SPFE_BYTE_W-2:0], 1'b0};
            if (cnt_inc == `SPFE_ADDR_DONE) begin
              if ({rx_shift[0], sdi_lvl} == `SPFE_CHIP_ADDR) begin
                // address known: verification pattern may now be driven
                addressed <= 1'b1;
                sdo_oe_n  <= 1'b0;
                state     <= ST_INSTRUCTION_CODE;
              end else begin
                // another chip's frame: stay silent to the end of select
                state <= ST_SKIP;
              end
            end
          end
          ST_INSTRUCTION_CODE: begin
            if (cnt_inc == `SPFE_PARITY_DONE) begin
              par_good <= parity_ok(rx_shift[`SPFE_CODE_MSB:0], sdi_lvl);
              tx_shift <= tx_data;
              state    <= ST_DATA;
            end else begin
              rx_shift <= {rx_shift[`SPFE_RX_W-2:0], sdi_lvl};
              tx_shift <= {tx_shift[`SPFE_BYTE_W-2:0], 1'b0};
              if (cnt_inc == `SPFE_INSTRUCTION_CODE_DONE) begin
                decide_pend <= 1'b1;
              end
            end
          end
          ST_DATA: begin
            if (in_frame) begin
              // read data leaves MSB first; writes see zeros fill in behind
              tx_shift <= {tx_shift[`SPFE_BYTE_W-2:0], 1'b0};
              if (kind == `SPFE_KIND_WRITE) begin
                data_shift <= {data_shift[`SPFE_BYTE_W-2:0], sdi_lvl};
              end
              // a read never samples sdi past the instruction byte
            end else begin
              // seventeenth bit onward: nothing is taken, output held low
              tx_shift <= `SPFE_BYTE_ZERO;
              state    <= ST_SKIP;
            end
          end
          ST_SKIP: begin
            tx_shift <= `SPFE_BYTE_ZERO;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // classify the instruction once seven bits are in and load the answer byte
  // the table answers combinationally, so one clk after the seventh edge is
  // enough; busy is looked at only here, a later busy does not spoil the frame.
  // the answer must be ready before the eighth edge, which the minimum
  // serial half period guarantees.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      kind    <= `SPFE_KIND_NONE;
      invalid <= 1'b0;
      tx_data <= `SPFE_DATA_INVALID;
    end else if (ss_fall) begin
      kind    <= `SPFE_KIND_NONE;
      invalid <= 1'b0;
      tx_data <= `SPFE_DATA_INVALID;
    end else if (decide_pend) begin
      if (proc_busy) begin
        kind    <= `SPFE_KIND_NONE;
        invalid <= 1'b1;
        tx_data <= `SPFE_DATA_INVALID;
      end else if (code_is_read) begin
        kind    <= `SPFE_KIND_READ;
        invalid <= 1'b0;
        tx_data <= read_data;
      end else if (code_is_write) begin
        kind    <= `SPFE_KIND_WRITE;
        invalid <= 1'b0;
        tx_data <= `SPFE_DATA_WRITE;
      end else if (code_is_clear) begin
        kind    <= `SPFE_KIND_CLEAR;
        invalid <= 1'b0;
        tx_data <= `SPFE_DATA_WRITE;
      end else begin
        kind    <= `SPFE_KIND_NONE;
        invalid <= 1'b1;
        tx_data <= `SPFE_DATA_INVALID;
      end
    end
  end

  // commits at the end of select; clock level there tells a started extra bit
  // bit_cnt still holds the frame's count in the ss_rise cycle, since the
  // deselect branch clears it only at that same edge.
  // bad parity blocks the commit but is not a transfer error.
  wire frame_ok  = addressed & ~invalid & full_frame(bit_cnt) & par_good;
  wire do_write  = ss_rise & frame_ok & (kind == `SPFE_KIND_WRITE) & ~sclk_lvl;
  wire do_clear  = ss_rise & frame_ok & (kind == `SPFE_KIND_CLEAR);
  wire set_error = ss_rise & addressed & (invalid | ~full_frame(bit_cnt));
  // flag has left the pin once the eighth falling edge passes
  wire flag_sent = sclk_fall & (state == ST_INSTRUCTION_CODE) & (cnt_inc == `SPFE_PARITY_DONE);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      write_strobe          <= 1'b0;
      clear_diagnostics_cmd <= 1'b0;
      write_code            <= {`SPFE_CODE_W{1'b0}};
      write_data            <= `SPFE_BYTE_ZERO;
    end else begin
      write_strobe          <= do_write;
      clear_diagnostics_cmd <= do_clear;
      if (do_write) begin
        write_code <= rx_shift[`SPFE_CODE_MSB:0];
        write_data <= data_shift;
      end
    end
  end

  // set takes priority over the clear that follows the flag being sent
  // set and clear meet in one clk only if select rises with the eighth falling edge
  // (set only at select rise, clear only at the eighth edge); the priority then
  // keeps the error from being lost.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_error_flag <= `SPFE_FLAG_RESET;
    end else if (set_error) begin
      transfer_error_flag <= 1'b1;
    end else if (flag_sent) begin
      transfer_error_flag <= 1'b0;
    end
  end

endmodule // spfe_frontend

`default_nettype wire

// file: verification/spfe_frontend_asserts.sv
// spfe_frontend_asserts.sv: port timing checks for the serial front end.
// assumes pins change at clk edges and a serial half period of 6 clk.
`default_nettype none
module spfe_frontend_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       ss_n,
  input wire logic       sdo,
  input wire logic       sdo_oe_n,
  input wire logic       write_strobe,
  input wire logic [4:0] write_code,
  input wire logic [7:0] write_data,
  input wire logic       clear_diagnostics_cmd,
  input wire logic       transfer_error_flag,
  input wire logic       frame_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_idle_undriven: assert property (ss_n [*8] |-> sdo_oe_n && !frame_active)
    else $error("output driven while deselected");
  a_reset_undriven: assert property ($past(rst) |-> sdo_oe_n)
    else $error("output driven right after reset");
  a_addr_undriven: assert property ($rose(frame_active) |-> sdo_oe_n [*8])
    else $error("output driven during address bits");
  a_write_at_end: assert property (write_strobe |-> $past(ss_n, 4) && !$past(sclk, 4) ##1 !write_strobe)
    else $error("write commit outside frame end");
  a_clear_at_end: assert property (clear_diagnostics_cmd |-> $past(ss_n, 4) ##1 !clear_diagnostics_cmd)
    else $error("clear pulse outside frame end");
  a_wdata_held: assert property (!write_strobe |-> $stable(write_data) && $stable(write_code))
    else $error("write value moved without commit");
  a_flag_set_end: assert property ($rose(transfer_error_flag) |-> $past(ss_n, 4))
    else $error("error flag set inside frame");
  a_flag_clr_frame: assert property ($fell(transfer_error_flag) |-> frame_active)
    else $error("error flag cleared outside frame");
  a_sdo_after_fall: assert property ($changed(sdo) |-> !$past(sclk, 4) || ss_n)
    else $error("serial output moved while clock high");
endmodule // spfe_frontend_chk
bind spfe_frontend spfe_frontend_chk spfe_frontend_chk_i (.clk, .rst, .sclk, .ss_n, .sdo, .sdo_oe_n,
  .write_strobe, .write_code, .write_data, .clear_diagnostics_cmd, .transfer_error_flag, .frame_active);
`default_nettype wire

// file: verification/spfe_frontend_tb.sv
// spfe_frontend_tb.sv: self-checking bench for the serial front end.
// assumes the master model drives the pins and this bench plays the decode table.
`default_nettype none
module spfe_frontend_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, proc_busy = 0;
  logic        sclk, ss_n, sdi, sdo, sdo_oe_n, wr, clr, flag, act;
  logic [4:0]  code, wcode;
  logic [7:0]  wdata;
  logic [15:0] rx;
  int          n_errors = 0, n_tests = 0, nw = 0, nc = 0, dw, dc, cyc = 0;
  wire sdo_pin = sdo_oe_n ? 1'hZ : sdo;
  wire rd = code[4] === 1'h0; // decode table lives outside the block
  wire wrc = (code > 5'h10 && code < 5'h18) === 1'h1;
  wire clc = code === 5'h18;
  spfe_frontend spfe_frontend_i (.clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .proc_busy(proc_busy), .instruction_code(code), .code_is_read(rd),
    .code_is_write(wrc), .code_is_clear(clc), .read_data({code, 3'h5}), .write_strobe(wr),
    .write_code(wcode), .write_data(wdata), .clear_diagnostics_cmd(clr),
    .transfer_error_flag(flag), .frame_active(act));
  spfe_master spfe_master_i (.clk(clk), .sclk(sclk), .ss_n(ss_n), .sdi(sdi), .sdo_pin(sdo_pin));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    nw += int'(wr === 1'h1);
    nc += int'(clr === 1'h1);
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] fw(input logic [1:0] a, input logic [4:0] c, input bit bad, input logic [7:0] d);
    return {a, c, ^c ^ bad, d, 16'h0000}; // even parity over code and parity bit
  endfunction
  function automatic logic [7:0] vb(input logic f);
    return {2'hZ, 5'h15, f};
  endfunction
  // dw and dc count commits seen since the frame began
  task automatic run(input logic [31:0] w, input int n, input bit hi = 0);
    int w0, c0;
    w0 = nw;
    c0 = nc;
    spfe_master_i.frame(w, n, hi, rx);
    dw = nw - w0;
    dc = nc - c0;
  endtask
  task automatic t_read;
    run(fw(2'h0, 5'h03, 0, 8'hA5), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h1D, 16'h0000});
    run(fw(2'h0, 5'h0E, 1, 8'hC3), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h75, 16'h0000});
  endtask
  task automatic t_write;
    run(fw(2'h0, 5'h12, 0, 8'hA5), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h00, 16'h0100});
    check({19'h00000, wcode, wdata}, {19'h00000, 5'h12, 8'hA5});
    run(fw(2'h0, 5'h15, 1, 8'h3C), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h00, 16'h0000});
  endtask
  task automatic t_invalid;
    run(fw(2'h0, 5'h19, 0, 8'h00), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'hFF, 16'h0000});
    run(fw(2'h0, 5'h00, 0, 8'h00), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(1), 8'h05, 16'h0000});
  endtask
  task automatic t_count;
    run(fw(2'h0, 5'h11, 0, 8'h5A), 15);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h00, 16'h0000});
    run(fw(2'h0, 5'h14, 0, 8'h66) | 32'h00008000, 17);
    check({rx, dw[7:0], dc[7:0]}, {vb(1), 8'h00, 16'h0000});
    run(fw(2'h0, 5'h01, 0, 8'h00), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(1), 8'h0D, 16'h0000});
  endtask
  task automatic t_other;
    run({2'h1, 5'h03, 1'h0, 8'h00, 2'h0, 5'h12, 1'h0, 8'hA5}, 32);
    check({rx, dw[7:0], dc[7:0]}, {16'hZZZZ, 16'h0000});
  endtask
  task automatic t_clear;
    run(fw(2'h0, 5'h18, 0, 8'h00), 16);
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'h00, 16'h0001});
  endtask
  task automatic t_busy;
    @(posedge clk);
    proc_busy <= 1'h1;
    run(fw(2'h0, 5'h07, 0, 8'h00), 16);
    proc_busy <= 1'h0;
    check({rx, dw[7:0], dc[7:0]}, {vb(0), 8'hFF, 16'h0000});
    run(fw(2'h0, 5'h17, 0, 8'hC3), 16, 1);
    check({rx, dw[7:0], dc[7:0]}, {vb(1), 8'h00, 16'h0000});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    check({31'h00000000, sdo_oe_n}, 32'h00000001);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    t_read;
    t_write;
    t_invalid;
    t_count;
    t_other;
    t_clear;
    t_busy;
    end_sim;
  end
endmodule // spfe_frontend_tb
`default_nettype wire

// file: verification/spfe_master.sv
// spfe_master.sv: serial master model that sends command frames.
// assumes clk of 4 ns; 6 clk low plus 6 clk high give the 48 ns link period.
`default_nettype none
module spfe_master (
  input  wire logic clk,
  output var  logic sclk,
  output var  logic ss_n,
  output var  logic sdi,
  input  wire logic sdo_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'h0; // clock stands low between frames
    ss_n = 1'h1;
    sdi = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // rx is sampled just before each falling edge, long after the slave moved
  task automatic frame(input logic [31:0] w, input int n, input bit hi, output logic [15:0] rx);
    rx = 16'h0000;
    ss_n <= 1'h0;
    wt(6);
    for (int i = 0; i < n; i++) begin
      sdi <= w[31-i]; // instruction first, msb first
      wt(3);
      sclk <= 1'h1;
      wt(6);
      if (i < 16) rx[15-i] = sdo_pin;
      sclk <= 1'h0;
      wt(3);
    end
    if (hi) sclk <= 1'h1;
    wt(3);
    ss_n <= 1'h1;
    wt(3);
    sclk <= 1'h0;
    sdi <= ~sdi; // released line shows no stale bit
    wt(10);
  endtask
endmodule // spfe_master
`default_nettype wire
